// ### logic/sacs_adc_end.sv
// Converter end: conversion sequencer, sample hold and serial result output
//
// Contract
// - track input from clock 12 to clock 3
// - hold sample on third clock falling edge
// - host changes references clock 11 to 3
// - mode set only by start convert use
// - start seen low, next rise is clock 1
// - MSB presented after fourth clock falling edge
// - cycle lasts exactly twelve clocks
// - start high at fall 12 tri-states, idles
// - sync start after fall 12, next rise
// - sync mode keeps output high impedance between
// - start held low gives back-to-back cycles
// - free run drives output low between cycles
// - host raises start between rise 1, fall 12
// - host may add idle clocks, twelve minimum
// - start falling begins cycle, enables output; the code enables it at the next rise with start low
// - one link clock sequences conversion and output
// - output low from cycle start to MSB
// - eight bits out MSB first, one per clock
// - result is straight unsigned binary
// - host keeps clock running during a cycle
`timescale 1ns/1ps
module sacs_adc_end (
  // System clock and reset
  input  wire logic                       mclk_in,
  input  wire logic                       rst_n_in,
  // Link to the host
  sacs_link_if.adc                        link,
  // Converter core side
  input  wire logic [sacs_pkg::RES_W-1:0] sample_in,
  output logic      [sacs_pkg::RES_W-1:0] result_out,
  output logic                            result_valid_out,
  output logic                            tracking_out,
  output logic                            busy_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sacs_pkg::sacs_state_type          state_r;
  sacs_pkg::sacs_state_type          state_nxt;
  logic [sacs_pkg::IDX_W-1:0]        idx_r;
  logic [sacs_pkg::IDX_W-1:0]        idx_nxt;
  logic                              lclk_d_r;
  logic [sacs_pkg::RES_W-1:0]        held_r;
  logic [sacs_pkg::RES_W-1:0]        held_nxt;
  logic [sacs_pkg::RES_W-1:0]        shift_r;
  logic [sacs_pkg::RES_W-1:0]        shift_nxt;
  logic                              dout_r;
  logic                              dout_nxt;
  logic                              oe_r;
  logic                              oe_nxt;
  logic                              track_r;
  logic                              track_nxt;
  logic [sacs_pkg::RES_W-1:0]        result_r;
  logic                              rvalid_r;
  logic                              busy_r;

  // ----------------------------------------------------------------
  // Link clock edge detection
  // ----------------------------------------------------------------
  // The link clock is sampled as a plain synchronous input, so both
  // edges are seen one system clock after they happen on the pin.
  wire lclk_rise = link.conv_clk & ~lclk_d_r;
  wire lclk_fall = ~link.conv_clk & lclk_d_r;
  wire sc_low    = ~link.start_convert_n;

  // Position decode within the cycle
  wire in_conv   = (state_r == sacs_pkg::SACS_CONV);
  wire at_hold   = in_conv & (idx_r == sacs_pkg::CLK_HOLD);
  wire at_last   = in_conv & (idx_r == sacs_pkg::CLK_LAST);
  wire in_data   = in_conv & (idx_r >= sacs_pkg::CLK_MSB) & (idx_r <= sacs_pkg::CLK_LSB);
  wire at_lsb    = in_conv & (idx_r == sacs_pkg::CLK_LSB);

  // Cycle starts: from idle on a low start convert, or back to back
  // after clock 12 once the last fall found start convert still low.
  wire start_idle = (state_r == sacs_pkg::SACS_IDLE) & lclk_rise & sc_low;
  wire start_next = at_last & lclk_rise;

  // Result strobe is taken when the LSB leaves
  wire lsb_out    = at_lsb & lclk_fall;

  // ----------------------------------------------------------------
  // Clock index increment
  // ----------------------------------------------------------------
  function automatic logic [sacs_pkg::IDX_W-1:0] clk_inc(input logic [sacs_pkg::IDX_W-1:0] idx);
    clk_inc = idx + sacs_pkg::CLK_FIRST;
  endfunction : clk_inc

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    case (state_r)
      sacs_pkg::SACS_IDLE:
      begin
        if (start_idle)
        begin
          state_nxt = sacs_pkg::SACS_CONV;
          idx_nxt   = sacs_pkg::CLK_FIRST;
        end
      end
      sacs_pkg::SACS_CONV:
      begin
        if (start_next)
          idx_nxt = sacs_pkg::CLK_FIRST;
        else if (lclk_rise)
          idx_nxt = clk_inc(idx_r);
        else if (at_last & lclk_fall & ~sc_low)
        begin
          state_nxt = sacs_pkg::SACS_IDLE;
          idx_nxt   = sacs_pkg::CLK_NONE;
        end
      end
      default:
      begin
        state_nxt = sacs_pkg::SACS_IDLE;
        idx_nxt   = sacs_pkg::CLK_NONE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Track and hold
  // ----------------------------------------------------------------
  // Tracking runs from the fall of clock 12 through clock 3; the held
  // value is frozen at the fall of clock 3 and ignores later input.
  always_comb
  begin
    track_nxt = track_r;
    held_nxt  = held_r;
    if (at_hold & lclk_fall)
    begin
      track_nxt = 1'b0;
      held_nxt  = sample_in;
    end
    else if (at_last & lclk_fall)
      track_nxt = 1'b1;
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  always_comb
  begin
    dout_nxt  = dout_r;
    oe_nxt    = oe_r;
    shift_nxt = shift_r;
    if (start_idle)
    begin
      oe_nxt   = 1'b1;
      dout_nxt = 1'b0;
    end
    else if (at_hold & lclk_fall)
      shift_nxt = sample_in;
    else if (in_data & lclk_fall)
    begin
      dout_nxt  = shift_r[sacs_pkg::RES_W-1];
      shift_nxt = {shift_r[sacs_pkg::RES_W-2:0], 1'b0};
    end
    else if (at_last & lclk_fall)
    begin
      dout_nxt = 1'b0;
      oe_nxt   = sc_low;
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      state_r  <= sacs_pkg::SACS_IDLE;
      idx_r    <= sacs_pkg::CLK_NONE;
      lclk_d_r <= 1'b0;
      track_r  <= 1'b1;
      busy_r   <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      idx_r    <= idx_nxt;
      lclk_d_r <= link.conv_clk;
      track_r  <= track_nxt;
      busy_r   <= (state_nxt == sacs_pkg::SACS_CONV);
    end
  end

  // Data path registers
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      held_r  <= '0;
      shift_r <= '0;
      dout_r  <= 1'b0;
      oe_r    <= 1'b0;
    end
    else
    begin
      held_r  <= held_nxt;
      shift_r <= shift_nxt;
      dout_r  <= dout_nxt;
      oe_r    <= oe_nxt;
    end
  end

  // Result handed to the core side when the LSB leaves
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      result_r <= '0;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= lsb_out;
      if (lsb_out)
        result_r <= held_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.sdata_o      = dout_r;
  assign link.sdata_oe     = oe_r;
  assign result_out        = result_r;
  assign result_valid_out  = rvalid_r;
  assign tracking_out      = track_r;
  assign busy_out          = busy_r;

endmodule : sacs_adc_end

// ### logic/sacs_pkg.sv
// Shared constants for the serial converter sequencer and its host end
package sacs_pkg;

  // ----------------------------------------------------------------
  // Conversion cycle layout, in conversion clocks
  // ----------------------------------------------------------------
  localparam int         RES_W      = 8;        // Result width
  localparam int         IDX_W      = 4;        // Width of the clock index
  localparam logic [3:0] CLK_FIRST  = 4'h1;     // First conversion clock
  localparam logic [3:0] CLK_HOLD   = 4'h3;     // Sample is held on this fall
  localparam logic [3:0] CLK_MSB    = 4'h4;     // MSB leaves after this fall
  localparam logic [3:0] CLK_LSB    = 4'hB;     // LSB leaves after this fall
  localparam logic [3:0] CLK_LAST   = 4'hC;     // Twelfth and last clock
  localparam logic [3:0] CLK_NONE   = 4'h0;     // No cycle under way

  // ----------------------------------------------------------------
  // Host sampling window and link clock divider
  // ----------------------------------------------------------------
  localparam logic [3:0] CAP_FIRST  = 4'h5;     // Host takes the MSB at this rise
  localparam int         HALF_PER   = 2;        // Link clock half period in mclk cycles
  localparam int         MCLK_NS    = 10;       // System clock period
  localparam int         DOUT_DLY_NS = 8;       // Data valid after a falling edge
  localparam int         DOUT_DLY_CYC = (DOUT_DLY_NS + MCLK_NS - 1) / MCLK_NS;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SACS_IDLE,
    SACS_ARM,
    SACS_CONV
  } sacs_state_type;

endpackage : sacs_pkg

// ### logic/sacs_link_if.sv
// Link between the converter end and the host end
`timescale 1ns/1ps
interface sacs_link_if;

  // ----------------------------------------------------------------
  // Link wires
  // ----------------------------------------------------------------
  logic conv_clk;          // Conversion clock made by the host
  logic start_convert_n;   // Start convert, active low
  logic sdata_o;           // Serial data driven by the converter
  logic sdata_oe;          // High while the converter drives the data pin
  wire  sdata;             // Resolved data pin

  // Data pin; a released pin shows the inverse of the last bit, so a stray capture stands out
  assign sdata = sdata_oe ? sdata_o : ~sdata_o;

  modport adc (
    input  conv_clk,
    input  start_convert_n,
    output sdata_o,
    output sdata_oe
  );

  modport host (
    output conv_clk,
    output start_convert_n,
    input  sdata
  );

endinterface : sacs_link_if

// ### logic/sacs_host_end.sv
// Host end: link clock divider, start convert driver and serial capture
`timescale 1ns/1ps
module sacs_host_end #(
  parameter int HALF_PER = sacs_pkg::HALF_PER  // Link clock half period, at least 2
) (
  // System clock and reset
  input  wire logic                       mclk_in,
  input  wire logic                       rst_n_in,
  // Link to the converter
  sacs_link_if.host                       link,
  // User requests
  input  wire logic                       start_in,
  input  wire logic                       run_in,
  // User results
  output logic      [sacs_pkg::RES_W-1:0] data_out,
  output logic                            data_valid_out,
  output logic                            busy_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sacs_pkg::sacs_state_type          state_r;
  sacs_pkg::sacs_state_type          state_nxt;
  logic [15:0]                       div_r;
  logic                              lclk_r;
  logic                              sc_n_r;
  logic                              sc_n_nxt;
  logic [sacs_pkg::IDX_W-1:0]        idx_r;
  logic [sacs_pkg::IDX_W-1:0]        idx_nxt;
  logic [sacs_pkg::RES_W-1:0]        shift_r;
  logic [sacs_pkg::RES_W-1:0]        data_r;
  logic                              valid_r;
  logic                              busy_r;

  // ----------------------------------------------------------------
  // Link clock divider, free running so a cycle never sees it stop
  // ----------------------------------------------------------------
  wire div_end = (div_r == 16'(HALF_PER - 1));
  wire rise    = div_end & ~lclk_r;
  wire fall    = div_end & lclk_r;
  wire in_conv = (state_r == sacs_pkg::SACS_CONV);
  wire at_last = in_conv & (idx_r == sacs_pkg::CLK_LAST);
  wire capture = in_conv & rise & (idx_r >= sacs_pkg::CLK_MSB) & (idx_r <= sacs_pkg::CLK_LSB);
  wire done    = in_conv & rise & (idx_r == sacs_pkg::CLK_LSB);

  // ----------------------------------------------------------------
  // Start convert sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    sc_n_nxt  = sc_n_r;
    case (state_r)
      sacs_pkg::SACS_IDLE:
      begin
        if (start_in | run_in)
        begin
          sc_n_nxt  = 1'b0;
          state_nxt = sacs_pkg::SACS_ARM;
          // Start lowered on the edge the link clock rises: the converter
          // counts that rise as clock one, so follow it at once
          if (rise)
          begin
            state_nxt = sacs_pkg::SACS_CONV;
            idx_nxt   = sacs_pkg::CLK_FIRST;
          end
        end
      end
      sacs_pkg::SACS_ARM:
      begin
        if (rise)
        begin
          state_nxt = sacs_pkg::SACS_CONV;
          idx_nxt   = sacs_pkg::CLK_FIRST;
        end
      end
      sacs_pkg::SACS_CONV:
      begin
        if (rise)
          idx_nxt = at_last ? sacs_pkg::CLK_FIRST : idx_r + sacs_pkg::CLK_FIRST;
        else if (at_last & fall & sc_n_r)
        begin
          state_nxt = sacs_pkg::SACS_IDLE;
          idx_nxt   = sacs_pkg::CLK_NONE;
        end
        else if (~rise & ~fall & (idx_r != sacs_pkg::CLK_LAST))
          sc_n_nxt = ~run_in;
      end
      default:
      begin
        state_nxt = sacs_pkg::SACS_IDLE;
        sc_n_nxt  = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      div_r   <= 16'h0000;
      lclk_r  <= 1'b0;
      state_r <= sacs_pkg::SACS_IDLE;
      idx_r   <= sacs_pkg::CLK_NONE;
      sc_n_r  <= 1'b1;
      busy_r  <= 1'b0;
    end
    else
    begin
      div_r   <= div_end ? 16'h0000 : div_r + 16'h0001;
      lclk_r  <= div_end ? ~lclk_r : lclk_r;
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      sc_n_r  <= sc_n_nxt;
      busy_r  <= (state_nxt != sacs_pkg::SACS_IDLE);
    end
  end

  // Serial capture on the rise after each falling-edge update
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      shift_r <= '0;
      data_r  <= '0;
      valid_r <= 1'b0;
    end
    else
    begin
      valid_r <= done;
      if (capture)
        shift_r <= {shift_r[sacs_pkg::RES_W-2:0], link.sdata};
      if (done)
        data_r <= {shift_r[sacs_pkg::RES_W-2:0], link.sdata};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.conv_clk        = lclk_r;
  assign link.start_convert_n = sc_n_r;
  assign data_out             = data_r;
  assign data_valid_out       = valid_r;
  assign busy_out             = busy_r;

endmodule : sacs_host_end

// ### tb/sacs_link_assertions.sv
// Checker for the link between the converter end and the host end
`timescale 1ns/1ps
module sacs_link_assertions (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Link wires
  input wire logic conv_clk,
  input wire logic start_convert_n,
  input wire logic sdata_o,
  input wire logic sdata_oe,
  input wire logic sdata
);
  // ----------------------------------------------------------------
  // Link clock edges and conversion clock index
  // ----------------------------------------------------------------
  logic       cc_r;
  logic       sc_f_r;
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;
  logic [3:0] fall_age_r;
  logic [3:0] idle_cnt_r;
  logic [3:0] stuck_r;
  wire        rise = conv_clk & ~cc_r;
  wire        fall = ~conv_clk & cc_r;
  wire        go   = ~start_convert_n | ((idx_r == 4'hC) & ~sc_f_r);

  // Start level at fall 12 or in idle decides the next clock one
  assign idx_nxt = (idx_r != 4'h0 && idx_r != 4'hC) ? idx_r + 4'h1 : (go ? 4'h1 : 4'h0);

  // Follow edges, clock index, time since a fall, idle time and clock stalls
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      cc_r       <= 1'b0;
      sc_f_r     <= 1'b1;
      idx_r      <= 4'h0;
      fall_age_r <= 4'h0;
      idle_cnt_r <= 4'h0;
      stuck_r    <= 4'h0;
    end
    else
    begin
      cc_r       <= conv_clk;
      sc_f_r     <= (fall && idx_r == 4'hC) ? start_convert_n : sc_f_r;
      idx_r      <= rise ? idx_nxt : idx_r;
      fall_age_r <= fall ? 4'h0 : ((fall_age_r == 4'hF) ? 4'hF : fall_age_r + 4'h1);
      idle_cnt_r <= (idx_r != 4'h0) ? 4'h0 : ((idle_cnt_r == 4'hF) ? 4'hF : idle_cnt_r + 4'h1);
      stuck_r    <= (conv_clk != cc_r) ? 4'h0 : ((stuck_r == 4'hF) ? 4'hF : stuck_r + 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_start_drive;
    rise && !start_convert_n && (idx_r == 4'h0 || (idx_r == 4'hC && sc_f_r)) |-> ##[1:3] (sdata_oe && !sdata_o);
  endproperty
  a_start_drive: assert property (p_start_drive)
    else $error("output not driven low at conversion start");

  property p_low_to_msb;
    (idx_r >= 4'h1 && idx_r <= 4'h3 && sdata_oe) |-> !sdata_o;
  endproperty
  a_low_to_msb: assert property (p_low_to_msb)
    else $error("output not low before the first result bit");

  property p_oe_in_cycle;
    (idx_r >= 4'h2 && idx_r <= 4'hB) |-> sdata_oe;
  endproperty
  a_oe_in_cycle: assert property (p_oe_in_cycle)
    else $error("output released inside a conversion");

  property p_bits_on_fall;
    (idx_r >= 4'h4 && $changed(sdata_o)) |-> fall_age_r <= 4'h3;
  endproperty
  a_bits_on_fall: assert property (p_bits_on_fall)
    else $error("data bit changed away from a falling link clock edge");

  property p_end_release;
    fall && idx_r == 4'hC && start_convert_n |-> ##[1:3] !sdata_oe;
  endproperty
  a_end_release: assert property (p_end_release)
    else $error("output not released at the end of a single conversion");

  property p_idle_hiz;
    (idle_cnt_r >= 4'h3 && idx_r == 4'h0) |-> !sdata_oe;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz)
    else $error("output driven while idle");

  property p_free_low;
    fall && idx_r == 4'hC && !start_convert_n |-> ##3 (sdata_oe && !sdata) [*3];
  endproperty
  a_free_low: assert property (p_free_low)
    else $error("output not held low between back to back conversions");

  property p_start_raise;
    $rose(start_convert_n) |-> idx_r != 4'h0;
  endproperty
  a_start_raise: assert property (p_start_raise)
    else $error("start raised outside a conversion");

  property p_clock_runs;
    idx_r != 4'h0 |-> stuck_r < 4'h4;
  endproperty
  a_clock_runs: assert property (p_clock_runs)
    else $error("link clock stalled inside a conversion");

endmodule : sacs_link_assertions

// ### tb/serial_adc_conversion_sequencer_tb.sv
// Self-checking bench joining the converter end and the host end
`timescale 1ns/1ps
module serial_adc_conversion_sequencer_tb;
  // ----------------------------------------------------------------
  // Stimulus, results and bookkeeping
  // ----------------------------------------------------------------
  logic                         mclk_in          = 1'b0;
  logic                         rst_n_in         = 1'b0;
  logic                         start_in         = 1'b0;
  logic                         run_in           = 1'b0;
  logic [sacs_pkg::RES_W-1:0]   sample_in        = 8'h00;
  logic [7:0]                   lfsr_r           = 8'h0D;
  logic [sacs_pkg::RES_W-1:0]   data_out;
  logic [sacs_pkg::RES_W-1:0]   result_out;
  logic                         data_valid_out;
  logic                         result_valid_out;
  logic                         tracking_out;
  logic                         host_busy;
  logic                         adc_busy;
  logic [sacs_pkg::RES_W-1:0]   q_host[$];
  logic [sacs_pkg::RES_W-1:0]   q_adc[$];
  logic [sacs_pkg::RES_W-1:0]   tbl[4] = '{8'h00, 8'hFF, 8'h80, 8'h01};
  int                           fails        = 0;
  int                           total_checks = 0;
  int                           cycles       = 0;
  int                           i;

  // ----------------------------------------------------------------
  // Both ends, their link and the link checker
  // ----------------------------------------------------------------
  sacs_link_if i_sacs_link_if ();
  sacs_adc_end i_sacs_adc_end (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .link(i_sacs_link_if.adc),
    .sample_in(sample_in), .result_out(result_out), .result_valid_out(result_valid_out),
    .tracking_out(tracking_out), .busy_out(adc_busy));
  sacs_host_end #(.HALF_PER(sacs_pkg::HALF_PER)) i_sacs_host_end (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .link(i_sacs_link_if.host), .start_in(start_in), .run_in(run_in), .data_out(data_out),
    .data_valid_out(data_valid_out), .busy_out(host_busy));
  sacs_link_assertions u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .conv_clk(i_sacs_link_if.conv_clk),
    .start_convert_n(i_sacs_link_if.start_convert_n), .sdata_o(i_sacs_link_if.sdata_o),
    .sdata_oe(i_sacs_link_if.sdata_oe), .sdata(i_sacs_link_if.sdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    lfsr_next = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next

  task automatic check_byte(input string name, input logic [sacs_pkg::RES_W-1:0] exp,
                            input logic [sacs_pkg::RES_W-1:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check_byte

  task automatic check_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  task automatic print_verdict();
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic wait_track(input logic lvl);
    while (tracking_out !== lvl)
      @(posedge mclk_in);
  endtask : wait_track

  // Run n conversions; the held sample is noted and then disturbed
  task automatic convert(input logic free, input int n);
    int k;
    start_in <= 1'b1;
    run_in   <= free;
    @(posedge mclk_in);
    start_in <= 1'b0;
    for (k = 0; k < n; k++)
    begin
      wait_track(1'b0);
      check_bit("adc_busy", 1'b1, adc_busy);
      q_host.push_back(sample_in);
      q_adc.push_back(sample_in);
      if (k == n - 1)
        run_in <= 1'b0;
      sample_in <= lfsr_r;
      lfsr_r    <= lfsr_next(lfsr_r);
      wait_track(1'b1);
    end
    while (host_busy !== 1'b0)
      @(posedge mclk_in);
  endtask : convert

  // ----------------------------------------------------------------
  // Clock, hang limit and result watcher
  // ----------------------------------------------------------------
  always #5 mclk_in = ~mclk_in;

  // Cut a hang short
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      print_verdict();
    end
  end

  // Compare each result with the oldest note
  always @(posedge mclk_in)
  begin
    if (data_valid_out === 1'b1)
      check_byte("data_out", (q_host.size() != 0) ? q_host.pop_front() : 'x, data_out);
    if (result_valid_out === 1'b1)
      check_byte("result_out", (q_adc.size() != 0) ? q_adc.pop_front() : 'x, result_out);
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    for (i = 0; i < 4; i++)
    begin
      sample_in <= tbl[i];
      convert(1'b0, 1);
      repeat (6) @(posedge mclk_in);
    end
    for (i = 0; i < 6; i++)
    begin
      repeat (lfsr_r[1:0]) @(posedge mclk_in);
      sample_in <= lfsr_r;
      lfsr_r    <= lfsr_next(lfsr_r);
      convert(1'b0, 1);
    end
    convert(1'b1, 5);
    repeat (10) @(posedge mclk_in);
    check_bit("adc_busy", 1'b0, adc_busy);
    check_bit("host_busy", 1'b0, host_busy);
    if (q_host.size() + q_adc.size() != 0)
    begin
      fails++;
      $display("Error queues expected 0 seen %0d", q_host.size() + q_adc.size());
    end
    print_verdict();
  end

endmodule : serial_adc_conversion_sequencer_tb
